//--- logic/pmtr_defines.vh
/*
 * Constants of the program memory table reader: register offsets, field
 * positions, reset values, memory geometry and serial frame lengths.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef PMTR_DEFINES_VH
`define PMTR_DEFINES_VH

// ***********************************************************************
// Register offsets on the plain register port.
// ***********************************************************************
`define PMTR_OFS_TPTR_LO    4'h0
`define PMTR_OFS_TPTR_HI    4'h1
`define PMTR_OFS_TBL_LATCH  4'h2
`define PMTR_OFS_BANK_SEL   4'h3
`define PMTR_OFS_STATUS     4'h4

// ***********************************************************************
// Field positions and reset values.
// ***********************************************************************
`define PMTR_BANK_MSB       2
`define PMTR_ST_BUSY        0
`define PMTR_ST_SECT_ERR    1
`define PMTR_ST_PROG        2
`define PMTR_RST_BYTE       8'h00
`define PMTR_RST_BANK       3'h0
`define PMTR_RST_PC         13'h0000

// ***********************************************************************
// Memory geometry.
// ***********************************************************************
`define PMTR_WORDS          49152
`define PMTR_ADDR_W         16
`define PMTR_LAST_PAGE_HI   8'hBF
`define PMTR_DEST_W         12
`define PMTR_SECT_MSB       11
`define PMTR_SECT_LSB       8

// ***********************************************************************
// Serial programming frame: one direction bit, address, then data.
// ***********************************************************************
`define PMTR_FR_ADDR_END    6'd17
`define PMTR_FR_END         6'd33

`endif

//--- logic/pmtr_prog_mem.v
/*
 * Program store of 48K 16-bit words with a fetch read port, a table read
 * port and one write port. Reads are registered: data stand one cycle
 * after the address. Addresses above the store read as zero.
 */
`include "pmtr_defines.vh"

module pmtr_prog_mem (
   input  wire                     clk_sys,
   input  wire [`PMTR_ADDR_W-1:0]  fetch_addr,
   output reg  [15:0]              fetch_word,
   input  wire [`PMTR_ADDR_W-1:0]  tab_addr,
   output reg  [15:0]              tab_word,
   input  wire                     wr_en,
   input  wire [`PMTR_ADDR_W-1:0]  wr_addr,
   input  wire [15:0]              wr_data
);

   // The store itself; no reset, flash contents survive a device reset.
   reg [15:0] mem_q [0:`PMTR_WORDS-1];

   // ***********************************************************************
   // Registered reads and the single write port.
   // ***********************************************************************
   // Out-of-range addresses return zero rather than aliasing a bank.
   always @(posedge clk_sys)
   begin
      if (fetch_addr < `PMTR_WORDS)
         fetch_word <= mem_q[fetch_addr];
      else
         fetch_word <= 16'h0000;
      if (tab_addr < `PMTR_WORDS)
         tab_word <= mem_q[tab_addr];
      else
         tab_word <= 16'h0000;
      if (wr_en && (wr_addr < `PMTR_WORDS))
         mem_q[wr_addr] <= wr_data;
   end

endmodule // pmtr_prog_mem

//--- logic/pmtr_reader.v
/*
 * Program memory access block: instruction fetch address with bank select,
 * the two-cycle table read path with its high byte latch, the register
 * port for software, and the serial in-circuit programming port.
 * Assumes all inputs are synchronous to clk_sys and that the CPU core
 * issues one table read at a time and keeps the pointer stable meanwhile.
 */
// Implementation choices: the plain strobed port and the address map.
`include "pmtr_defines.vh"

module pmtr_reader (
   input  wire                     clk_sys,
   input  wire                     rstn,
   // Register port.
   input  wire [3:0]               reg_addr,
   input  wire [7:0]               reg_wdata,
   input  wire                     reg_wr,
   input  wire                     reg_rd,
   output reg  [7:0]               reg_rdata,
   // Instruction fetch.
   input  wire                     fetch_next,
   input  wire                     jump_en,
   input  wire [12:0]              jump_addr,
   output reg  [`PMTR_ADDR_W-1:0]  fetch_pc,
   output wire [15:0]              fetch_word,
   // Table read requests from the CPU core.
   input  wire                     tab_start,
   input  wire                     tab_ext,
   input  wire                     tab_last,
   input  wire                     tab_abort,
   input  wire [`PMTR_DEST_W-1:0]  tab_dest,
   output reg                      dm_wr,
   output reg  [`PMTR_DEST_W-1:0]  dm_addr,
   output reg  [7:0]               dm_wdata,
   output reg                      tab_busy,
   output reg                      tab_refused,
   // Serial programming link.
   input  wire                     prog_mode,
   input  wire                     prog_serial_clock,
   input  wire                     prog_serial_data_in,
   output reg                      prog_serial_data_out,
   output reg                      prog_serial_data_oe_n
);

   // ***********************************************************************
   // Table read sequencer states.
   // ***********************************************************************
   localparam [1:0] ST_IDLE  = 2'b00;
   localparam [1:0] ST_CYC1  = 2'b01;
   localparam [1:0] ST_CYC2  = 2'b10;

   reg  [1:0]               state_q;        // Sequencer state.
   reg  [1:0]               state_d;        // Next sequencer state.
   reg  [7:0]               tptr_lo_q;      // Table pointer low byte.
   reg  [7:0]               tptr_hi_q;      // Table pointer high byte.
   reg  [7:0]               table_high_byte_latch_q; // High byte latch.
   reg  [2:0]               program_bank_select_q;   // Active bank.
   reg  [12:0]              pc_q;           // Offset inside the bank.
   reg                      sect_err_q;     // Sticky refused-form flag.
   reg  [`PMTR_ADDR_W-1:0]  tab_addr_q;     // Captured table address.
   reg  [`PMTR_DEST_W-1:0]  dest_q;         // Captured destination.
   reg                      prog_clk_q;     // Previous serial clock level.
   reg  [5:0]               bit_cnt_q;      // Serial frame bit counter.
   reg                      prog_rd_q;      // Frame direction: 1 is read.
   reg  [`PMTR_ADDR_W-1:0]  prog_addr_q;    // Serial frame address.
   reg  [15:0]              prog_shift_q;   // Serial data shifter.
   reg                      prog_wr_q;      // One-cycle store write.
   wire [15:0]              tab_word;       // Registered table word.
   wire [`PMTR_ADDR_W-1:0]  tab_addr_w;     // Address for the table port.
   wire                     plain_bad;      // Plain form, sector not zero.
   wire                     clk_rise;       // Serial clock rising.
   wire                     clk_fall;       // Serial clock falling.

   // ***********************************************************************
   // Memory instance.
   // ***********************************************************************
   // Programming reads share the table port; the two never overlap
   // because table reads are refused while the programming mode is on.
   assign tab_addr_w = prog_mode ? prog_addr_q : tab_addr_q;

   pmtr_prog_mem u_mem (
      .clk_sys    (clk_sys),
      .fetch_addr (fetch_pc),
      .fetch_word (fetch_word),
      .tab_addr   (tab_addr_w),
      .tab_word   (tab_word),
      .wr_en      (prog_wr_q),
      .wr_addr    (prog_addr_q),
      .wr_data    (prog_shift_q)
   );

   // ***********************************************************************
   // Instruction fetch address.
   // ***********************************************************************
   // The bank select only takes effect on the next jump or fetch_next step, which
   // matches how a bank change is followed by a far jump in software.
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         pc_q     <= `PMTR_RST_PC;
         fetch_pc <= 16'h0000;
      end
      else if (jump_en)
      begin
         pc_q     <= jump_addr;
         fetch_pc <= {program_bank_select_q, jump_addr};
      end
      else if (fetch_next)
      begin
         pc_q     <= pc_q + 13'h0001;
         fetch_pc <= {program_bank_select_q, pc_q + 13'h0001};
      end
   end

   // ***********************************************************************
   // Table read sequencer.
   // ***********************************************************************
   // A plain form aimed outside sector zero is refused and flagged.
   assign plain_bad = !tab_ext && (tab_dest[`PMTR_SECT_MSB:`PMTR_SECT_LSB] != 4'h0);

   // Next-state logic: issue cycle, then the completion cycle.
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (tab_start && !plain_bad && !prog_mode)
               state_d = ST_CYC1;
         end
         ST_CYC1:
         begin
            state_d = tab_abort ? ST_IDLE : ST_CYC2;
         end
         ST_CYC2:
         begin
            state_d = ST_IDLE;
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Captures the request and performs the low byte write-back to data memory.
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q     <= ST_IDLE;
         tab_addr_q  <= 16'h0000;
         dest_q      <= 12'h000;
         dm_wr       <= 1'b0;
         dm_addr     <= 12'h000;
         dm_wdata    <= `PMTR_RST_BYTE;
         tab_busy    <= 1'b0;
         tab_refused <= 1'b0;
      end
      else
      begin
         state_q     <= state_d;
         tab_busy    <= (state_d != ST_IDLE);
         tab_refused <= (state_q == ST_IDLE) && tab_start && (plain_bad || prog_mode);
         dm_wr       <= 1'b0;
         if ((state_q == ST_IDLE) && tab_start)
         begin
            dest_q <= tab_dest;
            if (tab_last)
               tab_addr_q <= {`PMTR_LAST_PAGE_HI, tptr_lo_q};
            else
               tab_addr_q <= {tptr_hi_q, tptr_lo_q};
         end
         // The word arrives during cycle two; an abort there drops it.
         if ((state_q == ST_CYC2) && !tab_abort)
         begin
            dm_wr    <= 1'b1;
            dm_addr  <= dest_q;
            dm_wdata <= tab_word[7:0];
         end
      end
   end

   // ***********************************************************************
   // Software registers.
   // ***********************************************************************
   // The latch is written by both software and hardware; the table read
   // wins a tie so a completed instruction is never lost.
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         tptr_lo_q               <= `PMTR_RST_BYTE;
         tptr_hi_q               <= `PMTR_RST_BYTE;
         table_high_byte_latch_q <= `PMTR_RST_BYTE;
         program_bank_select_q   <= `PMTR_RST_BANK;
         sect_err_q              <= 1'b0;
      end
      else
      begin
         if (reg_wr && (reg_addr == `PMTR_OFS_TPTR_LO))
            tptr_lo_q <= reg_wdata;
         if (reg_wr && (reg_addr == `PMTR_OFS_TPTR_HI))
            tptr_hi_q <= reg_wdata;
         if (reg_wr && (reg_addr == `PMTR_OFS_BANK_SEL))
            program_bank_select_q <= reg_wdata[`PMTR_BANK_MSB:0];
         if ((state_q == ST_CYC2) && !tab_abort)
            table_high_byte_latch_q <= tab_word[15:8];
         else if (reg_wr && (reg_addr == `PMTR_OFS_TBL_LATCH))
            table_high_byte_latch_q <= reg_wdata;
         // Sticky error: a new refusal wins over a write-one clear.
         if ((state_q == ST_IDLE) && tab_start && plain_bad)
            sect_err_q <= 1'b1;
         else if (reg_wr && (reg_addr == `PMTR_OFS_STATUS) && reg_wdata[`PMTR_ST_SECT_ERR])
            sect_err_q <= 1'b0;
      end
   end

   // Read data stand in the cycle after the strobe; unmapped reads zero.
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         reg_rdata <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            `PMTR_OFS_TPTR_LO:   reg_rdata <= tptr_lo_q;
            `PMTR_OFS_TPTR_HI:   reg_rdata <= tptr_hi_q;
            `PMTR_OFS_TBL_LATCH: reg_rdata <= table_high_byte_latch_q;
            `PMTR_OFS_BANK_SEL:  reg_rdata <= {5'h00, program_bank_select_q};
            `PMTR_OFS_STATUS:    reg_rdata <= {5'h00, prog_mode, sect_err_q, tab_busy};
            default:             reg_rdata <= 8'h00;
         endcase
      end
      else
         reg_rdata <= 8'h00;
   end

   // ***********************************************************************
   // Serial programming port.
   // ***********************************************************************
   // Frame: direction bit, 16 address bits MSB first, then 16 data bits.
   // The programmer samples on its rising edge; the device changes its
   // output after the falling edge so data are stable for a half period.
   assign clk_rise = prog_serial_clock && !prog_clk_q;
   assign clk_fall = !prog_serial_clock && prog_clk_q;

   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         prog_clk_q            <= 1'b0;
         bit_cnt_q             <= 6'd0;
         prog_rd_q             <= 1'b0;
         prog_addr_q           <= 16'h0000;
         prog_shift_q          <= 16'h0000;
         prog_wr_q             <= 1'b0;
         prog_serial_data_out  <= 1'b0;
         prog_serial_data_oe_n <= 1'b1;
      end
      else
      begin
         prog_clk_q <= prog_serial_clock;
         prog_wr_q  <= 1'b0;
         if (!prog_mode)
         begin
            // Leaving the mode aborts any partial frame and frees the line.
            bit_cnt_q             <= 6'd0;
            prog_serial_data_oe_n <= 1'b1;
         end
         else if (clk_rise)
         begin
            if (bit_cnt_q == 6'd0)
               prog_rd_q <= prog_serial_data_in;
            else if (bit_cnt_q < `PMTR_FR_ADDR_END)
               prog_addr_q <= {prog_addr_q[14:0], prog_serial_data_in};
            else if (!prog_rd_q)
               prog_shift_q <= {prog_shift_q[14:0], prog_serial_data_in};
            if (bit_cnt_q == (`PMTR_FR_END - 6'd1))
            begin
               bit_cnt_q <= 6'd0;
               prog_wr_q <= !prog_rd_q;
            end
            else
               bit_cnt_q <= bit_cnt_q + 6'd1;
         end
         else if (clk_fall && prog_rd_q)
         begin
            // Address is complete: load the word and drive its first bit.
            if (bit_cnt_q == `PMTR_FR_ADDR_END)
            begin
               prog_shift_q          <= {tab_word[14:0], 1'b0};
               prog_serial_data_out  <= tab_word[15];
               prog_serial_data_oe_n <= 1'b0;
            end
            else if (bit_cnt_q > `PMTR_FR_ADDR_END)
            begin
               prog_shift_q         <= {prog_shift_q[14:0], 1'b0};
               prog_serial_data_out <= prog_shift_q[15];
            end
            else
               prog_serial_data_oe_n <= 1'b1;
         end
         else if (clk_fall && (bit_cnt_q == 6'd0))
            prog_serial_data_oe_n <= 1'b1;
      end
   end

endmodule // pmtr_reader

//--- verification/pmtr_reader_sva.sv
/*
 * Checker of the table reader: assertions on the ports of pmtr_reader.
 * Assumes one clock, clk_sys, and the asynchronous active-low reset rstn.
 */
module pmtr_reader_sva (
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic [3:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        jump_en,
   input wire logic [12:0] jump_addr,
   input wire logic [15:0] fetch_pc,
   input wire logic        tab_start,
   input wire logic        tab_ext,
   input wire logic        tab_abort,
   input wire logic [11:0] tab_dest,
   input wire logic        dm_wr,
   input wire logic [11:0] dm_addr,
   input wire logic        tab_busy,
   input wire logic        tab_refused,
   input wire logic        prog_mode,
   input wire logic        prog_serial_data_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   // **********************************************************************
   // Helper logic.
   // **********************************************************************
   // A start that the block must accept: idle, not programming, legal sector.
   wire logic start_ok = tab_start && !tab_busy && !prog_mode && (tab_ext || tab_dest[11:8] == 4'h0);
   wire logic start_bad = tab_start && !tab_busy && (prog_mode || (!tab_ext && tab_dest[11:8] != 4'h0));
   logic [2:0]  bank_q;                      // Shadow of the bank select register.
   logic [11:0] dest_q;                      // Destination of the read in flight.

   // Shadows are kept here so the checker never peeks inside the design.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         bank_q <= 3'h0;
         dest_q <= 12'h000;
      end
      else
      begin
         if (reg_wr && reg_addr == 4'h3)
            bank_q <= reg_wdata[2:0];
         if (start_ok)
            dest_q <= tab_dest;
      end
   end

   // **********************************************************************
   // Assertions.
   // **********************************************************************
   a_pc_reset_zero: assert property ($rose(rstn) |-> fetch_pc == 16'h0000)
      else $error("fetch address not zero after reset");
   a_jump_bank_used: assert property (jump_en |=> fetch_pc == {$past(bank_q), $past(jump_addr)})
      else $error("jump target ignores bank select");
   a_tab_write_due: assert property (start_ok ##1 (!tab_abort) [*2] |-> ##[0:1] dm_wr)
      else $error("table read did not complete in two cycles");
   a_busy_span: assert property (start_ok ##1 !tab_abort |=> tab_busy ##1 !tab_busy)
      else $error("table read busy span not two cycles");
   a_tab_abort_quiet: assert property (start_ok ##1 tab_abort |-> (!dm_wr) [*3])
      else $error("aborted table read wrote data");
   a_tab_refuse_bad: assert property (start_bad |=> tab_refused ##0 (!dm_wr) [*3])
      else $error("illegal table read not refused");
   a_dest_match: assert property (dm_wr |-> dm_addr == dest_q)
      else $error("low byte written to wrong register");
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read answer cycle");
   a_oe_release: assert property ((!prog_mode) [*3] |-> prog_serial_data_oe_n)
      else $error("serial data driven outside programming");
endmodule // pmtr_reader_sva

bind pmtr_reader pmtr_reader_sva u_sva (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .jump_en(jump_en),
   .jump_addr(jump_addr), .fetch_pc(fetch_pc), .tab_start(tab_start), .tab_ext(tab_ext),
   .tab_abort(tab_abort), .tab_dest(tab_dest), .dm_wr(dm_wr), .dm_addr(dm_addr), .tab_busy(tab_busy),
   .tab_refused(tab_refused), .prog_mode(prog_mode), .prog_serial_data_oe_n(prog_serial_data_oe_n));

//--- verification/pmtr_dm_model.sv
/*
 * Data memory side of the CPU core: records each table read write-back.
 * Assumes dm_wr is a one-cycle pulse synchronous to clk_sys.
 */
module pmtr_dm_model (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        dm_wr,
   input  wire logic [11:0] dm_addr,
   input  wire logic [7:0]  dm_wdata,
   output logic      [11:0] last_addr,
   output logic      [7:0]  last_data,
   output int               wr_count
);
   timeunit 1ns;
   timeprecision 1ps;

   // Capture on the pulse only, so a stuck or doubled pulse shows in the count.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         last_addr <= 12'h000;
         last_data <= 8'h00;
         wr_count  <= 0;
      end
      else if (dm_wr)
      begin
         last_addr <= dm_addr;
         last_data <= dm_wdata;
         wr_count  <= wr_count + 1;
      end
   end
endmodule // pmtr_dm_model

//--- verification/tb_program_memory_table_reader.sv
/*
 * Testbench of the table reader: register, table read, fetch and serial tests.
 * Assumes pmtr_reader with its store, the data memory model and the bound checker.
 */
`define CHK(n,e,g) begin checked++; if ((g)!==(e)) begin err_count++; $display("MISMATCH %s exp %h got %h",n,e,g); end end
module tb_program_memory_table_reader;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, fetch_next = 1'b0, jump_en = 1'b0;
   logic tab_start = 1'b0, tab_ext = 1'b0, tab_last = 1'b0, tab_abort = 1'b0;
   logic prog_mode = 1'b0, prog_serial_clock = 1'b0, tb_sd = 1'b0, refd;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata, dm_wdata, last_data;
   logic [12:0] jump_addr = 13'h0000;
   logic [11:0] tab_dest = 12'h000, dm_addr, last_addr;
   logic [15:0] fetch_pc, fetch_word, q16;
   logic        dm_wr, tab_busy, tab_refused, sd_out, sd_oe_n;
   int          err_count = 0, checked = 0, cycles = 0, wr_count;
   // The shared data line: the device wins while it drives, else the programmer.
   wire logic   sdata = sd_oe_n ? tb_sd : sd_out;

   always #10 clk_sys = ~clk_sys;

   pmtr_reader dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_next(fetch_next), .jump_en(jump_en),
      .jump_addr(jump_addr), .fetch_pc(fetch_pc), .fetch_word(fetch_word), .tab_start(tab_start),
      .tab_ext(tab_ext), .tab_last(tab_last), .tab_abort(tab_abort), .tab_dest(tab_dest), .dm_wr(dm_wr),
      .dm_addr(dm_addr), .dm_wdata(dm_wdata), .tab_busy(tab_busy), .tab_refused(tab_refused),
      .prog_mode(prog_mode), .prog_serial_clock(prog_serial_clock), .prog_serial_data_in(sdata),
      .prog_serial_data_out(sd_out), .prog_serial_data_oe_n(sd_oe_n));
   pmtr_dm_model u_dm (.clk_sys(clk_sys), .rstn(rstn), .dm_wr(dm_wr), .dm_addr(dm_addr),
      .dm_wdata(dm_wdata), .last_addr(last_addr), .last_data(last_data), .wr_count(wr_count));

   // **********************************************************************
   // Tasks.
   // **********************************************************************
   task automatic complete_run;
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic chk_reg(input string n, input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      `CHK(n, e, reg_rdata)
   endtask

   // Abort, when asked, is raised in the cycle after the start.
   task automatic tab_read(input logic ext, input logic last, input logic [11:0] dest, input logic ab);
      @(posedge clk_sys);
      tab_start <= 1'b1;
      tab_ext <= ext;
      tab_last <= last;
      tab_dest <= dest;
      @(posedge clk_sys);
      tab_start <= 1'b0;
      tab_abort <= ab;
      #1 refd = tab_refused;
      @(posedge clk_sys);
      tab_abort <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask

   // One frame: direction, address MSB first, data; half periods of four cycles.
   task automatic ser_frame(input logic rd, input logic [15:0] a, input logic [15:0] d);
      logic [32:0] bits;
      bits = {rd, a, d};
      for (int i = 32; i >= 0; i--)
      begin
         @(posedge clk_sys);
         tb_sd <= bits[i];
         repeat (3) @(posedge clk_sys);
         if (i < 16)
            q16[i] = sdata;
         prog_serial_clock <= 1'b1;
         repeat (4) @(posedge clk_sys);
         prog_serial_clock <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
   endtask

   // A hang ends the run as a failure.
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         complete_run();
      end
   end

   // **********************************************************************
   // Tests.
   // **********************************************************************
   initial
   begin
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      #1;
      `CHK("fetch_pc reset", 16'h0000, fetch_pc)
      for (int a = 0; a < 5; a++)
         chk_reg("reset value", a[3:0], 8'h00);
      chk_reg("unmapped", 4'hF, 8'h00);
      $display("test reset done");
      prog_mode <= 1'b1;
      ser_frame(1'b0, 16'h0123, 16'hA55A);
      ser_frame(1'b0, 16'hBF05, 16'h000F);
      ser_frame(1'b0, 16'hBF06, 16'h001A);
      ser_frame(1'b1, 16'h0123, 16'h0000);
      `CHK("serial read", 16'hA55A, q16)
      chk_reg("status prog", 4'h4, 8'h04);
      tab_read(1'b1, 1'b0, 12'h020, 1'b0);
      `CHK("refused prog", 1'b1, refd)
      prog_mode <= 1'b0;
      $display("test serial done");
      reg_write(4'h0, 8'h06);
      reg_write(4'h1, 8'hBF);
      tab_read(1'b0, 1'b0, 12'h020, 1'b0);
      `CHK("dm data", 8'h1A, last_data)
      `CHK("dm addr", 12'h020, last_addr)
      chk_reg("latch zero", 4'h2, 8'h00);
      reg_write(4'h0, 8'h05);
      reg_write(4'h1, 8'h00);
      tab_read(1'b0, 1'b1, 12'h021, 1'b0);
      `CHK("last page", 8'h0F, last_data)
      reg_write(4'h0, 8'h23);
      reg_write(4'h1, 8'h01);
      tab_read(1'b1, 1'b0, 12'h320, 1'b0);
      `CHK("ext data", 8'h5A, last_data)
      chk_reg("latch high", 4'h2, 8'hA5);
      `CHK("write count", 3, wr_count)
      $display("test table read done");
      tab_read(1'b0, 1'b0, 12'h320, 1'b0);
      `CHK("refused sector", 1'b1, refd)
      chk_reg("sect err", 4'h4, 8'h02);
      reg_write(4'h4, 8'h02);
      chk_reg("sect clear", 4'h4, 8'h00);
      tab_read(1'b1, 1'b0, 12'h100, 1'b1);
      `CHK("no write", 3, wr_count)
      chk_reg("latch kept", 4'h2, 8'hA5);
      reg_write(4'h2, 8'h3C);
      chk_reg("latch rw", 4'h2, 8'h3C);
      $display("test refuse abort latch done");
      reg_write(4'h3, 8'h05);
      @(posedge clk_sys);
      jump_en <= 1'b1;
      jump_addr <= 13'h1F05;
      @(posedge clk_sys);
      jump_en <= 1'b0;
      #1;
      `CHK("jump pc", 16'hBF05, fetch_pc)
      @(posedge clk_sys);
      fetch_next <= 1'b1;
      #1;
      `CHK("fetch word", 16'h000F, fetch_word)
      @(posedge clk_sys);
      fetch_next <= 1'b0;
      @(posedge clk_sys);
      #1;
      `CHK("next word", 16'h001A, fetch_word)
      `CHK("next pc", 16'hBF06, fetch_pc)
      $display("test fetch done");
      complete_run();
   end
endmodule // tb_program_memory_table_reader
